// >>> hw/bgt_pkg.sv
package bgt_pkg;

  // =====================================================
  // clock and time base
  localparam int CLK_NS = 10;
  localparam int TICK_US = 10;
  localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
  localparam logic [9:0] TICK_LAST = 10'(TICK_CYC - 1);
  // one tick closes 2 * TICK_US of the requested period
  localparam logic [27:0] PER_STEP_US = 28'(2 * TICK_US);
  localparam logic [27:0] PER_MIN_US = 28'd20;
  localparam logic [27:0] PER_MAX_US = 28'd200000000;

  // =====================================================
  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] PERIOD_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // =====================================================
  // field positions
  localparam int CTRL_TSRC = 0;
  localparam int CTRL_GSRC = 2;
  localparam int CTRL_AUXLF = 4;
  localparam int CTRL_FSK = 5;
  localparam int CTRL_AM = 6;
  localparam int CMD_BURST = 0;
  localparam int CMD_GATE = 1;
  localparam int CMD_SYNC = 2;
  localparam int COUNT_HALF = 10;

  // =====================================================
  // reset values
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [27:0] PERIOD_RST = 28'h00003e8;
  localparam logic [10:0] COUNT_RST = 11'h001;

  typedef enum logic [1:0] {
    SRC_EXT = 2'h0,
    SRC_MAN = 2'h1,
    SRC_INTERNAL_TRIGGER_SOURCE = 2'h2
  } bgt_src_t;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } bgt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bgt_apb_rsp_t;

endpackage

// >>> hw/bgt_ctrl.sv
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// - burst mode: trigger edge emits programmed cycles
// - gated mode: output runs while gate high
// - internal square wave, period 0.02ms to 200s
// - unrealisable period rounds up to next longer
// - internal square wave drives trigger output
// - internal source burst: every rising edge
// - internal source gate: high half passes
// - external source burst: each rising edge
// - external source gate: while input high
// - burst key toggles burst, lamp shows
// - burst source: external, manual, internal
// - manual source: one burst per press
// - report users of shared internal generator
// - count 1..1023 whole or 0.5..511.5 halves
// - burst starts and stops at set phase
// - start on aux output rising edge, stop on its rising or falling edge
// - fast sine/triangle: phase only in low mode
// - gate key toggles gating, lamp shows
// - gate source selectable; true gate passes
// - gating unsynchronised, jumps at edges
// - manual gate toggles per press
module bgt_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire bgt_pkg::bgt_apb_req_t apb_req,
  output bgt_pkg::bgt_apb_rsp_t apb_rsp,
  input wire logic external_trigger_input,
  input wire logic manual_sync_key,
  input wire logic aux_out,
  input wire logic main_zero_sq,
  input wire logic fast_sine_tri,
  output logic main_enable,
  output logic trigger_sweep_output,
  output logic burst_lamp,
  output logic gate_lamp
);
  import bgt_pkg::*;

  // =====================================================
  // register bus
  logic [6:0] ctrl_r;
  logic [27:0] period_r;
  logic [10:0] count_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic burst_on_r;
  logic gate_on_r;
  logic burst_run_r;
  logic gate_true;
  logic internal_trigger_source_r;
  logic [31:0] status_w;
  logic [31:0] rd_w;
  logic hit_w;
  logic wr_w;
  logic [7:0] ofs_w;
  logic [3:0] users_w;
  bgt_src_t tsrc;
  bgt_src_t gsrc;

  assign ofs_w = apb_req.paddr[7:0];
  assign wr_w = apb_req.psel & apb_req.penable & apb_req.pwrite
    & pready_r;
  assign tsrc = bgt_src_t'(ctrl_r[CTRL_TSRC +: 2]);
  assign gsrc = bgt_src_t'(ctrl_r[CTRL_GSRC +: 2]);

  // order: gate, fsk, am, burst
  assign users_w = {
    gate_on_r & (gsrc == SRC_INTERNAL_TRIGGER_SOURCE),
    ctrl_r[CTRL_FSK],
    ctrl_r[CTRL_AM],
    burst_on_r & (tsrc == SRC_INTERNAL_TRIGGER_SOURCE)};

  assign status_w = {22'h000000, users_w,
    ~|users_w, internal_trigger_source_r, gate_true, burst_run_r,
    gate_on_r, burst_on_r};

  always_comb begin
    hit_w = 1'b1;
    rd_w = 32'h00000000;
    unique case (ofs_w)
      CTRL_OFS: rd_w = {25'h0000000, ctrl_r};
      CMD_OFS: rd_w = 32'h00000000;
      PERIOD_OFS: rd_w = {4'h0, period_r};
      COUNT_OFS: rd_w = {21'h000000, count_r};
      STATUS_OFS: rd_w = status_w;
      default: hit_w = 1'b0;
    endcase
    if (apb_req.paddr[31:8] != 24'h000000) begin
      hit_w = 1'b0;
    end
  end

  // answer in the first cycle of the access phase, without wait states
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= apb_req.psel & ~apb_req.penable;
      if (apb_req.psel & ~apb_req.penable) begin
        prdata_r <= (apb_req.pwrite | ~hit_w) ?
          32'h00000000 : rd_w;
        pslverr_r <= ~hit_w;
      end
    end
  end

  assign apb_rsp.prdata = prdata_r;
  assign apb_rsp.pready = pready_r;
  assign apb_rsp.pslverr = pslverr_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      period_r <= PERIOD_RST;
      count_r <= COUNT_RST;
    end else if (wr_w) begin
      if (ofs_w == CTRL_OFS) begin
        ctrl_r <= apb_req.pwdata[6:0];
      end
      if (ofs_w == PERIOD_OFS) begin
        // out-of-range requests are pinned to the limits
        if (apb_req.pwdata[31:0] < {4'h0, PER_MIN_US}) begin
          period_r <= PER_MIN_US;
        end else if (apb_req.pwdata > {4'h0, PER_MAX_US}) begin
          period_r <= PER_MAX_US;
        end else begin
          period_r <= apb_req.pwdata[27:0];
        end
      end
      if (ofs_w == COUNT_OFS) begin
        // a zero count is raised to the smallest burst
        if (apb_req.pwdata[9:0] == 10'h000) begin
          count_r <= {apb_req.pwdata[COUNT_HALF], 10'h001};
        end else begin
          count_r <= apb_req.pwdata[10:0];
        end
      end
    end
  end

  // =====================================================
  // key presses and remote commands
  logic cmd_burst;
  logic cmd_gate;
  logic cmd_sync;
  logic key_d_r;
  logic sync_press;

  assign cmd_burst = wr_w & (ofs_w == CMD_OFS)
    & apb_req.pwdata[CMD_BURST];
  assign cmd_gate = wr_w & (ofs_w == CMD_OFS)
    & apb_req.pwdata[CMD_GATE];
  assign cmd_sync = wr_w & (ofs_w == CMD_OFS)
    & apb_req.pwdata[CMD_SYNC];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_d_r <= 1'b0;
    end else begin
      key_d_r <= manual_sync_key;
    end
  end

  assign sync_press = (manual_sync_key & ~key_d_r) | cmd_sync;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      burst_on_r <= 1'b0;
      gate_on_r <= 1'b0;
    end else begin
      if (cmd_burst) begin
        burst_on_r <= ~burst_on_r;
      end
      if (cmd_gate) begin
        gate_on_r <= ~gate_on_r;
      end
    end
  end

  // =====================================================
  // external input synchroniser
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_d_r;
  logic ext_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_d_r <= 1'b0;
    end else begin
      ext_s1_r <= external_trigger_input;
      ext_s2_r <= ext_s1_r;
      ext_d_r <= ext_s2_r;
    end
  end

  // 50 ns is five clocks, so no legal pulse slips past
  assign ext_rise = ext_s2_r & ~ext_d_r;

  // =====================================================
  // internal trigger generator
  logic [9:0] pre_r;
  logic tick;
  logic [27:0] elapsed_r;
  logic internal_trigger_source_d_r;
  logic internal_trigger_source_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_r <= 10'h000;
    end else if (pre_r == TICK_LAST) begin
      pre_r <= 10'h000;
    end else begin
      pre_r <= pre_r + 10'h001;
    end
  end

  assign tick = pre_r == TICK_LAST;

  // each tick covers one step of the period; a half ends
  // at the first tick where the steps reach the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      elapsed_r <= 28'h0000000;
      internal_trigger_source_r <= 1'b0;
    end else if (tick) begin
      if (elapsed_r + PER_STEP_US >= period_r) begin
        elapsed_r <= 28'h0000000;
        internal_trigger_source_r <= ~internal_trigger_source_r;
      end else begin
        elapsed_r <= elapsed_r + PER_STEP_US;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      internal_trigger_source_d_r <= 1'b0;
    end else begin
      internal_trigger_source_d_r <= internal_trigger_source_r;
    end
  end

  assign internal_trigger_source_rise = internal_trigger_source_r & ~internal_trigger_source_d_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trigger_sweep_output <= 1'b0;
    end else begin
      trigger_sweep_output <= internal_trigger_source_r;
    end
  end

  // =====================================================
  // trigger selection
  logic burst_mode_key_evt;

  always_comb begin
    unique case (tsrc)
      SRC_MAN: burst_mode_key_evt = sync_press;
      SRC_INTERNAL_TRIGGER_SOURCE: burst_mode_key_evt = internal_trigger_source_rise;
      default: burst_mode_key_evt = ext_rise;
    endcase
  end

  // =====================================================
  // phase reference edges
  logic ref_lvl;
  logic ref_d_r;
  logic ref_rise;
  logic ref_edge;

  // without low-frequency aux mode a fast sine or
  // triangle falls back to the zero-phase square
  assign ref_lvl = (fast_sine_tri & ~ctrl_r[CTRL_AUXLF]) ?
    main_zero_sq : aux_out;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_d_r <= 1'b0;
    end else begin
      ref_d_r <= ref_lvl;
    end
  end

  assign ref_rise = ref_lvl & ~ref_d_r;
  assign ref_edge = ref_lvl ^ ref_d_r;

  // =====================================================
  // burst sequencer
  typedef enum logic [1:0] {
    B_IDLE,
    B_ARM,
    B_RUN
  } bgt_bst_t;

  bgt_bst_t bst_r;
  logic [10:0] halves_r;
  logic [10:0] target;

  // whole-cycle counts are converted to half cycles
  assign target = count_r[COUNT_HALF] ?
    {1'b0, count_r[9:0]} : {count_r[9:0], 1'b0};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bst_r <= B_IDLE;
      halves_r <= 11'h000;
    end else if (~burst_on_r) begin
      bst_r <= B_IDLE;
      halves_r <= 11'h000;
    end else begin
      unique case (bst_r)
        B_IDLE: begin
          if (burst_mode_key_evt) begin
            bst_r <= B_ARM;
          end
        end
        B_ARM: begin
          if (ref_rise) begin
            bst_r <= B_RUN;
            halves_r <= 11'h000;
          end
        end
        B_RUN: begin
          if (ref_edge) begin
            if (halves_r + 11'h001 == target) begin
              bst_r <= B_IDLE;
            end
            halves_r <= halves_r + 11'h001;
          end
        end
      endcase
    end
  end

  assign burst_run_r = bst_r == B_RUN;

  // =====================================================
  // gate selection
  logic gate_man_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_man_r <= 1'b0;
    end else if (sync_press & (gsrc == SRC_MAN)) begin
      gate_man_r <= ~gate_man_r;
    end
  end

  always_comb begin
    unique case (gsrc)
      SRC_MAN: gate_true = gate_man_r;
      SRC_INTERNAL_TRIGGER_SOURCE: gate_true = internal_trigger_source_r;
      default: gate_true = ext_s2_r;
    endcase
  end

  // =====================================================
  // main output enable
  // the waveform keeps running; only the gate switches,
  // so the output jumps to and from the offset level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      main_enable <= 1'b1;
      burst_lamp <= 1'b0;
      gate_lamp <= 1'b0;
    end else begin
      burst_lamp <= burst_on_r;
      gate_lamp <= gate_on_r;
      if (burst_on_r) begin
        main_enable <= bst_r == B_RUN;
      end else if (gate_on_r) begin
        main_enable <= gate_true;
      end else begin
        main_enable <= 1'b1;
      end
    end
  end

endmodule

// >>> verification/bgt_chk.sv
`timescale 1ns/100ps
module bgt_chk
  import bgt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire bgt_pkg::bgt_apb_req_t apb_req,
  input wire bgt_pkg::bgt_apb_rsp_t apb_rsp,
  input wire logic external_trigger_input,
  input wire logic manual_sync_key,
  input wire logic aux_out,
  input wire logic main_zero_sq,
  input wire logic fast_sine_tri,
  input wire logic main_enable,
  input wire logic trigger_sweep_output,
  input wire logic burst_lamp,
  input wire logic gate_lamp
);
  // ==================================================
  // bus phases, shadow of the source selection
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic setup;
  logic done;
  logic [6:0] ctrl_r;
  assign setup = apb_req.psel && !apb_req.penable;
  assign done = apb_req.psel && apb_req.penable && apb_rsp.pready
    && apb_req.pwrite && apb_req.paddr[31:8] == 24'h0;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      ctrl_r <= CTRL_RST;
    else if (done && apb_req.paddr[7:0] == CTRL_OFS)
      ctrl_r <= apb_req.pwdata[6:0];
  end
  // ==================================================
  // assertions
  chk_ready_setup: assert property (setup |=> apb_rsp.pready)
    else $error("no pready after setup");
  chk_err_unmapped: assert property (setup && apb_req.paddr > 32'h10
    |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_burst_key: assert property (done && apb_req.paddr[7:0] == CMD_OFS
    && apb_req.pwdata[CMD_BURST] |=> ##[0:1] $changed(burst_lamp))
    else $error("burst lamp did not toggle");
  chk_gate_key: assert property (done && apb_req.paddr[7:0] == CMD_OFS
    && apb_req.pwdata[CMD_GATE] |=> ##[0:1] $changed(gate_lamp))
    else $error("gate lamp did not toggle");
  chk_square_hold: assert property ($changed(trigger_sweep_output)
    |=> $stable(trigger_sweep_output)[*8])
    else $error("square half too short");
  chk_reset_out: assert property ($fell(rst) |-> main_enable
    && !burst_lamp && !gate_lamp && !trigger_sweep_output)
    else $error("outputs wrong after reset");
  chk_gate_ext: assert property ((gate_lamp && !burst_lamp
    && ctrl_r[3:2] == 2'h0 && $stable(external_trigger_input))[*6]
    |-> main_enable == external_trigger_input)
    else $error("gate does not follow input");
  chk_burst_mode_key_ext: assert property (burst_lamp && ctrl_r[1:0] == 2'h0
    && !main_enable && $rose(external_trigger_input)
    |-> ##[2:40] main_enable)
    else $error("trigger edge started no burst");
endmodule

bind bgt_ctrl bgt_chk chk_u (.clk(clk), .rst(rst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .external_trigger_input(external_trigger_input),
  .manual_sync_key(manual_sync_key), .aux_out(aux_out),
  .main_zero_sq(main_zero_sq), .fast_sine_tri(fast_sine_tri),
  .main_enable(main_enable), .trigger_sweep_output(trigger_sweep_output),
  .burst_lamp(burst_lamp), .gate_lamp(gate_lamp));

// >>> verification/bgt_ext_src.sv
`timescale 1ns/100ps
module bgt_ext_src (
  input wire logic clk,
  output logic ext
);
  // ==================================================
  // pulse source; the line rests low between pulses
  int since = 100;
  initial ext = 1'b0;
  always @(posedge clk) since <= ext ? 0 : since + 1;
  task automatic level(input int w);
    while (since < 100) @(posedge clk);
    ext <= 1'b1;
    repeat ((w < 5) ? 5 : w) @(posedge clk);
    ext <= 1'b0;
  endtask
endmodule

// >>> verification/tb.sv
`timescale 1ns/100ps
module tb;
  import bgt_pkg::*;
  // ==================================================
  // clock, stimulus, design
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic key = 1'b0;
  logic aux = 1'b0;
  logic sel = 1'b0;
  logic fst = 1'b0;
  logic zsq = 1'b0;
  logic ext, en, tso, bl, gl, err, mon;
  logic [31:0] d;
  logic [31:0] ctl [4] = '{32'h0, 32'h0, 32'h1, 32'h2};
  logic [31:0] cnt [4] = '{32'h3, 32'h403, 32'h7ff, 32'h1};
  logic [31:0] exp [4] = '{32'd60, 32'd30, 32'd10230, 32'd20};
  bgt_apb_req_t req = '0;
  bgt_apb_rsp_t rsp;
  int n_mismatch = 0;
  int n_checks = 0;
  int ac = 0;
  int n;
  assign mon = sel ? tso : en;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    ac <= ac + 1;
    aux <= ac % 20 < 10;
    // zero-phase square at half the aux rate, so the two
    // phase references give bursts of different lengths
    zsq <= ac % 40 < 20;
  end
  bgt_ctrl dut_u (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .external_trigger_input(ext), .manual_sync_key(key), .aux_out(aux),
    .main_zero_sq(zsq), .fast_sine_tri(fst), .main_enable(en),
    .trigger_sweep_output(tso), .burst_lamp(bl), .gate_lamp(gl));
  bgt_ext_src src_u (.clk(clk), .ext(ext));
  // ==================================================
  // tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string s, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] wd);
    int t = 0;
    @(posedge clk);
    req <= '{{24'h0, a}, 1'b1, 1'b0, w, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1 && t < 20) begin
      @(posedge clk);
      t++;
    end
    if (t == 20) begin
      n_mismatch++;
      $display("[ERR] pready wait expected %0d seen %0d", 1, 0);
      summarize();
    end
    // answer taken at the very edge that samples pready high
    d = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    cmp("read", e, d & m);
  endtask
  // high time of mon, after it has first been low
  task automatic meas(input int lim);
    int t = 0;
    n = 0;
    @(negedge clk);
    while (mon === 1'b1 && t < lim) begin
      @(negedge clk);
      t++;
    end
    while (mon !== 1'b1 && t < lim) begin
      @(negedge clk);
      t++;
    end
    while (mon === 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (t == lim || n == lim) begin
      n_mismatch++;
      $display("[ERR] wait limit expected %0d seen %0d", lim, t);
      summarize();
    end
  endtask
  task automatic press();
    key <= 1'b1;
    repeat (5) @(posedge clk);
    key <= 1'b0;
    repeat (5) @(negedge clk);
  endtask
  // ==================================================
  // tests
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    cmp("reset outputs", 32'h1, 32'({gl, bl, tso, en}));
    apb(1'b1, PERIOD_OFS, 32'd110);
    sel = 1'b1;
    meas(20000);
    cmp("square high", 32'd6000, 32'(n));
    sel = 1'b0;
    apb(1'b1, CTRL_OFS, 32'h8);
    apb(1'b1, CMD_OFS, 32'h2);
    meas(20000);
    cmp("gate internal", 32'd6000, 32'(n));
    apb(1'b1, CTRL_OFS, 32'h0);
    fork
      src_u.level(37);
      meas(200);
    join
    cmp("gate external", 32'd37, 32'(n));
    apb(1'b1, CTRL_OFS, 32'h4);
    press();
    cmp("manual open", 32'h1, 32'(en));
    apb(1'b1, CMD_OFS, 32'h4);
    repeat (5) @(negedge clk);
    cmp("remote close", 32'h0, 32'(en));
    apb(1'b1, CMD_OFS, 32'h3);
    repeat (2) @(negedge clk);
    cmp("lamps", 32'h1, 32'({gl, bl}));
    $display("done: gate");
    foreach (ctl[i]) begin
      apb(1'b1, COUNT_OFS, cnt[i]);
      apb(1'b1, CTRL_OFS, ctl[i]);
      fork
        if (ctl[i] == 32'h0) src_u.level(5);
        if (ctl[i] == 32'h1) press();
        meas(30000);
      join
      cmp("burst length", exp[i], 32'(n));
    end
    $display("done: burst");
    fst <= 1'b1;
    apb(1'b1, CTRL_OFS, 32'h1);
    fork
      press();
      meas(30000);
    join
    cmp("zero phase ref", 32'd40, 32'(n));
    apb(1'b1, CTRL_OFS, 32'h11);
    fork
      press();
      meas(30000);
    join
    cmp("aux phase ref", 32'd20, 32'(n));
    fst <= 1'b0;
    $display("done: phase");
    rd(COUNT_OFS, '1, 32'h1);
    apb(1'b1, COUNT_OFS, 32'h0);
    rd(COUNT_OFS, '1, 32'h1);
    apb(1'b1, PERIOD_OFS, 32'h5);
    rd(PERIOD_OFS, '1, 32'd20);
    apb(1'b1, PERIOD_OFS, 32'hfffffff);
    rd(PERIOD_OFS, '1, 32'd200000000);
    apb(1'b1, CTRL_OFS, 32'h0);
    rd(STATUS_OFS, 32'h3e0, 32'h20);
    apb(1'b1, CTRL_OFS, 32'h22);
    rd(STATUS_OFS, 32'h3e0, 32'h140);
    apb(1'b0, 8'h14, 32'h0);
    cmp("unmapped", 32'h1, {d[30:0], err});
    apb(1'b1, CMD_OFS, 32'h1);
    rd(CTRL_OFS, '1, 32'h22);
    cmp("burst off", 32'h0, 32'(bl));
    $display("done: registers");
    summarize();
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule
